/* hw/status_led_mode_logic.sv */
`timescale 1ns/100ps
`include "status_led_regs.svh"
// Summary of operation
// - three lamp outputs follow one of three modes, two picked by strap and the third by control input.
// - in mode 1 the link lamp is steadily lit while link is good, with no blinking.
// - in modes 2 and 3 the link lamp is lit on good link and blinks while transmit or receive is active.
// - the speed lamp is lit at 100 Mb/s and dark at 10 Mb/s in every mode.
// - in mode 1 the third lamp is lit on transmit or receive activity.
// - in mode 2 the third lamp shows collision.
// - in mode 3 the third lamp is lit for full duplex.
// - the lamp pins double as event pins 5 to 7; direct control turns the lamp functions off.
module status_led_mode_logic
  import status_led_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = `LED_BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // strap and mode configuration
  input  wire logic       i_mode_strap,
  input  wire logic       i_mode3_sel,
  // direct control: lamps off, event pins own the pads
  input  wire logic [2:0] i_indicator_direct_control,
  // event pin drive from event logic
  input  wire logic       i_event_pin_5,
  input  wire logic       i_event_pin_6,
  input  wire logic       i_event_pin_7,
  input  wire logic       i_event_oe_5,
  input  wire logic       i_event_oe_6,
  input  wire logic       i_event_oe_7,
  // transceiver core status (same clock)
  input  wire logic       i_link_good,
  input  wire logic       i_speed_100,
  input  wire logic       i_full_duplex,
  input  wire logic       i_collision,
  input  wire logic       i_tx_active,
  input  wire logic       i_rx_active,
  // lamp pads
  output logic            o_link_indicator_out,
  output logic            o_speed_indicator_out,
  output logic            o_activity_indicator_out,
  output logic            o_link_indicator_oe,
  output logic            o_speed_indicator_oe,
  output logic            o_activity_indicator_oe,
  // current mode
  output led_mode_t       o_mode
);
  // pad index order: activity, speed, link, matching event pins 5, 6, 7
  localparam int unsigned PADS      = 3;
  localparam int unsigned PAD_ACT   = 0;
  localparam int unsigned PAD_SPEED = 1;
  localparam int unsigned PAD_LINK  = 2;

  led_status_if st ();

  // strap pin chain
  logic            strap_meta_reg;
  logic            strap_sync_reg;
  logic            strap_hold_reg;
  logic            strap_level_reg;
  // mode state
  logic            strap_taken_reg;
  led_mode_t       strap_mode_reg;
  led_mode_t       mode_reg;
  led_mode_t       mode_next;
  // lamp decode and pad drive
  led_bits_t       lamp_next;
  led_bits_t       off_bits;
  wire  [PADS-1:0] lamp_vec;
  wire  [PADS-1:0] off_vec;
  wire  [PADS-1:0] event_data_vec;
  wire  [PADS-1:0] event_oe_vec;
  wire  [PADS-1:0] pad_out_vec;
  wire  [PADS-1:0] pad_oe_vec;

  function automatic led_mode_t strap_decode(input logic level);
    return level ? MODE_TWO : MODE_ONE;
  endfunction : strap_decode

  // strap is a pin; a change counts once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    strap_meta_reg <= i_mode_strap;
    strap_sync_reg <= strap_meta_reg;
    strap_hold_reg <= strap_sync_reg;
  end

  // no reset, so the chain fills while reset is held; hold reset four clocks or more
  always_ff @(posedge i_ref_clk) begin
    if (strap_sync_reg == strap_hold_reg) begin
      strap_level_reg <= strap_hold_reg;
    end
  end

  // strap taken once per reset; later pin moves cannot shift the mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      strap_taken_reg <= 1'h0;
      strap_mode_reg  <= led_mode_t'(`LED_MODE_RESET);
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'h1;
      strap_mode_reg  <= strap_decode(strap_level_reg);
    end
  end

  always_comb begin
    mode_next = mode_reg;
    if (!strap_taken_reg) begin
      mode_next = strap_decode(strap_level_reg);
    end else if (i_mode3_sel) begin
      mode_next = MODE_THREE;
    end else begin
      mode_next = strap_mode_reg;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mode_reg <= led_mode_t'(`LED_MODE_RESET);
    end else begin
      mode_reg <= mode_next;
    end
  end

  // core status already on i_ref_clk, so no synchroniser
  assign st.link_good   = i_link_good;
  assign st.speed_100   = i_speed_100;
  assign st.full_duplex = i_full_duplex;
  assign st.collision   = i_collision;
  assign st.activity    = i_tx_active | i_rx_active;

  // timer idles while quiet, so every burst starts with the lamp lit
  led_blink_timer #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blink (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_run     (st.activity),
    .o_phase   (st.blink_phase)
  );

  // with link good, the link lamp goes dark only in modes 2 and 3, on the odd blink phase while traffic runs
  function automatic led_bits_t lamps(input led_mode_t m, input logic lk, input logic sp,
                                      input logic fd, input logic col, input logic act,
                                      input logic ph);
    led_bits_t b;
    b.speed = sp;
    case (m)
      MODE_ONE: begin
        b.link     = lk;
        b.activity = act;
      end
      MODE_TWO: begin
        b.link     = lk & ~(act & ph);
        b.activity = col;
      end
      MODE_THREE: begin
        b.link     = lk & ~(act & ph);
        b.activity = fd;
      end
      default: begin
        b.link     = 1'h0;
        b.activity = 1'h0;
      end
    endcase
    return b;
  endfunction : lamps

  always_comb begin
    lamp_next = lamps(mode_reg, st.link_good, st.speed_100, st.full_duplex,
                      st.collision, st.activity, st.blink_phase);
  end

  assign off_bits                  = led_bits_t'(i_indicator_direct_control);
  assign lamp_vec[PAD_LINK]        = lamp_next.link;
  assign lamp_vec[PAD_SPEED]       = lamp_next.speed;
  assign lamp_vec[PAD_ACT]         = lamp_next.activity;
  assign off_vec[PAD_LINK]         = off_bits.link;
  assign off_vec[PAD_SPEED]        = off_bits.speed;
  assign off_vec[PAD_ACT]          = off_bits.activity;
  assign event_data_vec[PAD_LINK]  = i_event_pin_7;
  assign event_data_vec[PAD_SPEED] = i_event_pin_6;
  assign event_data_vec[PAD_ACT]   = i_event_pin_5;
  assign event_oe_vec[PAD_LINK]    = i_event_oe_7;
  assign event_oe_vec[PAD_SPEED]   = i_event_oe_6;
  assign event_oe_vec[PAD_ACT]     = i_event_oe_5;

  // one registered stage per pad; event logic owns a pad once its lamp is off
  for (genvar p = 0; p < PADS; p++) begin : g_pad
    logic out_next;
    logic oe_next;
    logic out_reg;
    logic oe_reg;

    assign out_next = off_vec[p] ? event_data_vec[p] : lamp_vec[p];
    assign oe_next  = off_vec[p] ? event_oe_vec[p] : 1'h1;

    always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
        out_reg <= 1'h0;
        oe_reg  <= 1'h1;
      end else begin
        out_reg <= out_next;
        oe_reg  <= oe_next;
      end
    end

    assign pad_out_vec[p] = out_reg;
    assign pad_oe_vec[p]  = oe_reg;
  end

  // lamp pads
  assign o_link_indicator_out     = pad_out_vec[PAD_LINK];
  assign o_speed_indicator_out    = pad_out_vec[PAD_SPEED];
  assign o_activity_indicator_out = pad_out_vec[PAD_ACT];
  assign o_link_indicator_oe      = pad_oe_vec[PAD_LINK];
  assign o_speed_indicator_oe     = pad_oe_vec[PAD_SPEED];
  assign o_activity_indicator_oe  = pad_oe_vec[PAD_ACT];

  assign o_mode = mode_reg;
endmodule : status_led_mode_logic

/* hw/status_led_regs.svh */
`ifndef STATUS_LED_REGS_SVH
`define STATUS_LED_REGS_SVH

// blink half period in ms and its cycle count at 200 MHz
`define LED_CLK_HZ          200000000
`define LED_BLINK_HALF_MS   50
`define LED_BLINK_HALF_CYC  ((`LED_CLK_HZ / 1000) * `LED_BLINK_HALF_MS)
// mode field reset value (mode 1)
`define LED_MODE_RESET      2'h1

`endif

/* hw/status_led_pkg.sv */
package status_led_pkg;
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_ONE  = 2'h1,
    MODE_TWO  = 2'h2,
    MODE_THREE = 2'h3
  } led_mode_t;

  // per-lamp selection of driver for direct control
  typedef struct packed {
    logic link;
    logic speed;
    logic activity;
  } led_bits_t;
endpackage : status_led_pkg

/* hw/led_status_if.sv */
`timescale 1ns/100ps
// transceiver status, unsynchronised, and blink phase, bundled inside the mode logic
interface led_status_if;
  logic link_good;
  logic speed_100;
  logic full_duplex;
  logic collision;
  logic activity;
  logic blink_phase;
  modport producer (output link_good, output speed_100, output full_duplex,
                    output collision, output activity, output blink_phase);
  modport consumer (input link_good, input speed_100, input full_duplex,
                    input collision, input activity, input blink_phase);
endinterface : led_status_if

/* hw/led_blink_timer.sv */
`timescale 1ns/100ps
`include "status_led_regs.svh"
module led_blink_timer
  import status_led_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `LED_BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // control
  input  wire logic i_run,
  // output
  output logic      o_phase
);
  localparam int W = $clog2(HALF_CYCLES + 1);
  logic [W-1:0] cnt_reg;

  // divider runs only while i_run is high; phase restarts lit so activity shows at once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !i_run) begin
      cnt_reg <= '0;
      o_phase <= 1'b0;
    end else if (cnt_reg == W'(HALF_CYCLES - 1)) begin
      cnt_reg <= '0;
      o_phase <= ~o_phase;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end
endmodule : led_blink_timer

/* dv/status_led_properties.sv */
`timescale 1ns/100ps
module status_led_properties
  import status_led_pkg::*;
(
  input logic i_ref_clk, i_rstn, i_mode_strap, i_mode3_sel, i_event_pin_7, i_event_oe_7,
  input logic [2:0] i_indicator_direct_control,
  input logic i_link_good, i_speed_100, i_full_duplex, i_collision, i_tx_active, i_rx_active,
  input logic o_link_indicator_out, o_link_indicator_oe, o_speed_indicator_out, o_activity_indicator_out,
  input led_mode_t o_mode
);
  // mode must stay put across the checked edge, so mode 3 select gates each;
  // the strap edge right after reset may still move mode 1 away
  wire [2:0] dc  = i_indicator_direct_control;
  wire       ae  = !dc[0];
  wire       md1 = o_mode == MODE_ONE && !i_mode3_sel;
  wire       md2 = o_mode == MODE_TWO && !i_mode3_sel;
  wire       md3 = o_mode == MODE_THREE && i_mode3_sel;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_speed_lamp: assert property (!dc[1] |=> o_speed_indicator_out == $past(i_speed_100)) else $error("speed");
  a_link_steady: assert property (md1 && !dc[2] && !$rose(i_rstn)
    |=> o_link_indicator_out == $past(i_link_good)) else $error("link");
  a_link_dark: assert property (!i_link_good && !dc[2] |=> !o_link_indicator_out) else $error("link dark");
  a_act_lamp: assert property (md1 && ae && !$rose(i_rstn)
    |=> o_activity_indicator_out == $past(i_tx_active | i_rx_active)) else $error("act");
  a_col_lamp: assert property (md2 && ae |=> o_activity_indicator_out == $past(i_collision)) else $error("col");
  a_dup_lamp: assert property (md3 && ae |=> o_activity_indicator_out == $past(i_full_duplex)) else $error("dup");
  a_event_pad: assert property (dc[2] |=> o_link_indicator_oe == $past(i_event_oe_7)
    && o_link_indicator_out == $past(i_event_pin_7)) else $error("pad");
  a_strap_mode: assert property ($rose(i_rstn) && !i_mode3_sel
    |=> o_mode == ($past(i_mode_strap) ? MODE_TWO : MODE_ONE)) else $error("strap");
  c_mode3: cover property (o_mode == MODE_THREE && o_activity_indicator_out);
  c_blink: cover property (i_link_good && i_tx_active && $fell(o_link_indicator_out));
  c_event: cover property (dc[2] && !o_link_indicator_oe);
endmodule : status_led_properties

bind status_led_mode_logic status_led_properties i_status_led_properties (.*);

/* dv/led_lamp_model.sv */
`timescale 1ns/100ps
// pads carry pull-ups, so an undriven pad lights its lamp
module led_lamp_model (
  input  logic [2:0] i_pad,
  input  logic [2:0] i_oe,
  output logic [2:0] o_lit
);
  assign o_lit = (i_oe & i_pad) | ~i_oe;
endmodule : led_lamp_model

/* dv/status_led_mode_logic_tb.sv */
`timescale 1ns/100ps
module status_led_mode_logic_tb;
  import status_led_pkg::*;
  logic clk = 0, rstn = 0, st = 0, m3 = 0, lk = 0, sp = 0, fd = 0, col = 0, tx = 0, rx = 0;
  logic [2:0] dc = 3'h0, ev = 3'h0, eo = 3'h0, pad, oe, lit;
  led_mode_t md;
  int fails = 0, total_checks = 0, cyc = 0;
  status_led_mode_logic #(.BLINK_HALF_CYCLES(4)) i_status_led_mode_logic (.i_ref_clk(clk), .i_rstn(rstn),
    .i_mode_strap(st), .i_mode3_sel(m3), .i_indicator_direct_control(dc), .i_event_pin_5(ev[0]),
    .i_event_pin_6(ev[1]), .i_event_pin_7(ev[2]), .i_event_oe_5(eo[0]), .i_event_oe_6(eo[1]), .i_event_oe_7(eo[2]),
    .i_link_good(lk), .i_speed_100(sp), .i_full_duplex(fd), .i_collision(col), .i_tx_active(tx), .i_rx_active(rx),
    .o_link_indicator_out(pad[2]), .o_speed_indicator_out(pad[1]), .o_activity_indicator_out(pad[0]),
    .o_link_indicator_oe(oe[2]), .o_speed_indicator_oe(oe[1]), .o_activity_indicator_oe(oe[0]), .o_mode(md));
  led_lamp_model i_led_lamp_model (.i_pad(pad), .i_oe(oe), .o_lit(lit));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 1500) begin
    fails++;
    conclude();
  end
  task automatic w(int n); repeat (n) @(posedge clk); #1; endtask : w
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rst(logic s);
    @(posedge clk); rstn <= 0; st <= s;
    repeat (6) @(posedge clk); rstn <= 1; w(2);
    chk("mode", md, s ? MODE_TWO : MODE_ONE);
  endtask : rst
  // window starts inside the first lit stretch in mode 3 and in a dark stretch in mode 2; any 8 samples of steady blink hold 4 lit
  task automatic blink(logic t);
    logic [7:0] n = 0;
    @(posedge clk); lk <= 1; tx <= t; rx <= !t; w(2);
    repeat (8) begin w(1); n += lit[2]; end
    chk("blink", n, 8'h04);
    @(posedge clk); tx <= 0; rx <= 0;
  endtask : blink
  task automatic t_mode1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk); {lk, sp, tx, rx} <= 4'(i); w(7);
      chk("m1", lit, {i[3], i[2], i[1] | i[0]});
    end
    $display("mode 1 done");
  endtask : t_mode1
  task automatic t_mode3;
    @(posedge clk); m3 <= 1; sp <= 0; fd <= 1; tx <= 0; rx <= 0; w(3);
    chk("m3", {md, lit}, {MODE_THREE, 3'h5});
    @(posedge clk); fd <= 0; w(2); chk("fdx", lit, 3'h4);
    blink(1);
    @(posedge clk); m3 <= 0; w(3); chk("back", md, MODE_ONE);
    $display("mode 3 done");
  endtask : t_mode3
  task automatic t_direct;
    @(posedge clk); dc <= 3'h7; ev <= 3'h5; eo <= 3'h3; w(2);
    chk("pads", {oe, pad}, {3'h3, 3'h5});
    chk("lamps", lit, 3'h5);
    @(posedge clk); dc <= 3'h0; sp <= 1; w(2); chk("own", {oe, lit}, {3'h7, 3'h6});
    $display("direct done");
  endtask : t_direct
  task automatic t_mode2;
    rst(1);
    @(posedge clk); st <= 0; col <= 1; lk <= 0; w(2);
    chk("m2", {md, lit}, {MODE_TWO, 3'h3});
    @(posedge clk); col <= 0; tx <= 1; w(2); chk("col", lit, 3'h2);
    blink(0);
    $display("mode 2 done");
  endtask : t_mode2
  task automatic conclude;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    rst(0);
    t_mode1();
    t_mode3();
    t_direct();
    t_mode2();
    conclude();
  end
endmodule : status_led_mode_logic_tb
